// *** include/rcwd_pkg.sv ***
// Purpose: constants and carrier types for the reset configuration decoder
// Assumes: word bit 0 is the most significant of the 16-bit field
// Notes:   indices below are positions in a [0:15] numbered word
package rcwd_pkg;
    localparam int WORD_W           = 16;
    localparam int ARB_BIT          = 0;
    localparam int PREFIX_BIT       = 1;
    localparam int DRIVE_BIT        = 2;
    localparam int BOOT_DIS_BIT     = 3;
    localparam int WIDTH_HI_BIT     = 4;
    localparam int WIDTH_LO_BIT     = 5;
    localparam int RSV_FIRST_BIT    = 6;
    localparam int RSV_LAST_BIT     = 8;
    localparam int DBG_HI_BIT       = 9;
    localparam int DBG_LO_BIT       = 10;
    localparam int STROBE_BIT       = 12;
    localparam int DIV_HI_BIT       = 13;
    localparam int DIV_LO_BIT       = 14;
    localparam int INTERLOCK_BIT    = 15;

    localparam logic [1:0] WIDTH_32 = 2'h0;
    localparam logic [1:0] WIDTH_8  = 2'h1;
    localparam logic [1:0] WIDTH_16 = 2'h2;
    localparam logic [1:0] WIDTH_RSV = 2'h3;

    // default word: every field zero selects the power-on default
    localparam logic [15:0] DEFAULT_WORD = 16'h0000;

    typedef struct packed {
        logic       arbitration_select;
        logic       vector_prefix_init;
        logic       bus_drive_reduce;
        logic       boot_cs_disable;
        logic [1:0] boot_width;
        logic [1:0] debug_pin_config;
        logic       strobe_type_select;
        logic [1:0] bus_clock_divide;
        logic       interlock_target_select;
    } rcwd_settings_s;
endpackage : rcwd_pkg

// *** verilog/rcwd_decode.sv ***
// Purpose: capture the reset configuration word and hold decoded settings
// Assumes: word inputs are stable and synchronous to clk while in reset
// Notes:   settings reset to defaults, then follow the word until release
//
// How it works
// - bit 0 picks internal or external arbiter
// - bit 1 seeds the interrupt prefix bit
// - bit 2 reduces bus pin and clock drive
// - bit 3 clear activates bank 0 boot
// - bank 0 option write ends boot overrides
// - bits 4-5 give boot port width
// - bits 9-10 give debug pin configuration
// - bit 12 picks strobe or address type
// - bits 13-14 give bus clock divide
// - bit 15 picks interlock write target
// - interlock select always from flash word
`timescale 1ns/1ps
module rcwd_decode (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    reset_active,
    input  wire logic [15:0]             reset_config_word,
    input  wire logic [15:0]             flash_config_word,
    input  wire logic                    bank0_option_write,
    output rcwd_pkg::rcwd_settings_s     settings,
    output logic                         bank0_boot_active,
    output logic                         bank0_match_all,
    output logic                         boot_overrides_live,
    output logic                         reserved_bits_error
);
    // one-hot phases of the bank 0 hand-over
    typedef enum logic [2:0] {
        RCWD_PH_LOAD = 3'h1,
        RCWD_PH_BOOT = 3'h2,
        RCWD_PH_SOFT = 3'h4
    } rcwd_phase_e;

    localparam int WIDTH_W = rcwd_pkg::WIDTH_LO_BIT
                           - rcwd_pkg::WIDTH_HI_BIT + 1;
    localparam int DBG_W   = rcwd_pkg::DBG_LO_BIT
                           - rcwd_pkg::DBG_HI_BIT + 1;
    localparam int DIV_W   = rcwd_pkg::DIV_LO_BIT
                           - rcwd_pkg::DIV_HI_BIT + 1;
    localparam int RSV_W   = rcwd_pkg::RSV_LAST_BIT
                           - rcwd_pkg::RSV_FIRST_BIT + 1;

    rcwd_pkg::rcwd_settings_s    next_settings;
    rcwd_phase_e                 phase;
    rcwd_phase_e                 next_phase;
    logic [0:rcwd_pkg::WORD_W-1] word;
    logic [0:rcwd_pkg::WORD_W-1] fword;
    logic                        arb_bit;
    logic                        prefix_bit;
    logic                        drive_bit;
    logic                        boot_dis_bit;
    logic [WIDTH_W-1:0]          width_field;
    logic [DBG_W-1:0]            dbg_field;
    logic                        strobe_bit;
    logic [DIV_W-1:0]            div_field;
    logic                        interlock_bit;
    logic [RSV_W-1:0]            rsv_field;
    logic                        next_live;

    // reverse so index 0 names the most significant bit
    always_comb begin
        for (int i = 0; i < rcwd_pkg::WORD_W; i++) begin
            word[i]  = reset_config_word[15-i];
            fword[i] = flash_config_word[15-i];
        end
    end

    // one extractor per field keeps the bit numbering in one place
    rcwd_field #(
        .FIRST (rcwd_pkg::ARB_BIT),
        .FW    (1)
    ) u_arb (
        .word  (word),
        .field (arb_bit)
    );
    rcwd_field #(
        .FIRST (rcwd_pkg::PREFIX_BIT),
        .FW    (1)
    ) u_prefix (
        .word  (word),
        .field (prefix_bit)
    );
    rcwd_field #(
        .FIRST (rcwd_pkg::DRIVE_BIT),
        .FW    (1)
    ) u_drive (
        .word  (word),
        .field (drive_bit)
    );
    rcwd_field #(
        .FIRST (rcwd_pkg::BOOT_DIS_BIT),
        .FW    (1)
    ) u_boot_dis (
        .word  (word),
        .field (boot_dis_bit)
    );
    rcwd_field #(
        .FIRST (rcwd_pkg::WIDTH_HI_BIT),
        .FW    (WIDTH_W)
    ) u_width (
        .word  (word),
        .field (width_field)
    );
    rcwd_field #(
        .FIRST (rcwd_pkg::DBG_HI_BIT),
        .FW    (DBG_W)
    ) u_dbg (
        .word  (word),
        .field (dbg_field)
    );
    rcwd_field #(
        .FIRST (rcwd_pkg::STROBE_BIT),
        .FW    (1)
    ) u_strobe (
        .word  (word),
        .field (strobe_bit)
    );
    rcwd_field #(
        .FIRST (rcwd_pkg::DIV_HI_BIT),
        .FW    (DIV_W)
    ) u_div (
        .word  (word),
        .field (div_field)
    );
    rcwd_field #(
        .FIRST (rcwd_pkg::RSV_FIRST_BIT),
        .FW    (RSV_W)
    ) u_rsv (
        .word  (word),
        .field (rsv_field)
    );
    // the flash word alone feeds the interlock select
    rcwd_field #(
        .FIRST (rcwd_pkg::INTERLOCK_BIT),
        .FW    (1)
    ) u_lock (
        .word  (fword),
        .field (interlock_bit)
    );

    always_comb begin
        next_settings.arbitration_select      = arb_bit;
        next_settings.vector_prefix_init      = prefix_bit;
        next_settings.bus_drive_reduce        = drive_bit;
        next_settings.boot_cs_disable         = boot_dis_bit;
        next_settings.boot_width              = width_field;
        next_settings.debug_pin_config        = dbg_field;
        next_settings.strobe_type_select      = strobe_bit;
        next_settings.bus_clock_divide        = div_field;
        // the external or default word never supplies this bit
        next_settings.interlock_target_select = interlock_bit;
    end

    // sampled each cycle of reset, frozen at release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // all-zero settings are the power-on defaults
            settings <= '0;
        end else if (reset_active) begin
            settings <= next_settings;
        end
    end

    // option writes count only once reset has let go
    always_comb begin
        next_phase = phase;
        case (phase)
            RCWD_PH_LOAD: begin
                if (reset_active) begin
                    next_phase = RCWD_PH_LOAD;
                end else if (bank0_option_write) begin
                    next_phase = RCWD_PH_SOFT;
                end else begin
                    next_phase = RCWD_PH_BOOT;
                end
            end
            RCWD_PH_BOOT: begin
                if (reset_active) begin
                    next_phase = RCWD_PH_LOAD;
                end else if (bank0_option_write) begin
                    next_phase = RCWD_PH_SOFT;
                end else begin
                    next_phase = RCWD_PH_BOOT;
                end
            end
            RCWD_PH_SOFT: begin
                if (reset_active) begin
                    next_phase = RCWD_PH_LOAD;
                end else begin
                    next_phase = RCWD_PH_SOFT;
                end
            end
            default: begin
                next_phase = RCWD_PH_LOAD;
            end
        endcase
    end

    assign next_live = (next_phase != RCWD_PH_SOFT);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= RCWD_PH_LOAD;
        end else begin
            phase <= next_phase;
        end
    end

    // registered so the boot outputs never glitch on the phase decode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_overrides_live <= 1'b1;
        end else begin
            boot_overrides_live <= next_live;
        end
    end

    // reserved bits are the supplier's duty; flag only for visibility
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reserved_bits_error <= 1'b0;
        end else if (reset_active) begin
            reserved_bits_error <= |rsv_field;
        end
    end

    assign bank0_boot_active = boot_overrides_live
                             & ~settings.boot_cs_disable;
    assign bank0_match_all   = bank0_boot_active;
endmodule : rcwd_decode

// picks a field from a word numbered 0 at its most significant end
module rcwd_field #(
    parameter int FIRST = 0,
    parameter int FW    = 1
) (
    input  wire logic [0:rcwd_pkg::WORD_W-1] word,
    output logic      [FW-1:0]               field
);
    assign field = word[FIRST +: FW];
endmodule : rcwd_field

// *** bench/rcwd_decode_properties.sv ***
// Purpose: checker on the decoder ports
// Assumes: word bit n sits at vector bit 15-n
// Notes:   bound to every rcwd_decode
`timescale 1ns/1ps
module rcwd_decode_properties (
    input wire logic                     clk,
    input wire logic                     rst_n,
    input wire logic                     reset_active,
    input wire logic                     bank0_option_write,
    input wire logic [15:0]              reset_config_word,
    input wire logic [15:0]              flash_config_word,
    input wire rcwd_pkg::rcwd_settings_s settings,
    input wire logic                     bank0_boot_active,
    input wire logic                     bank0_match_all,
    input wire logic                     boot_overrides_live,
    input wire logic                     reserved_bits_error
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence load_s;
        reset_active;
    endsequence
    sequence sw_write_s;
        !reset_active && bank0_option_write;
    endsequence
    // a new reset phase may bring the overrides back one cycle on
    sequence live_gone_s;
        !boot_overrides_live
            ##1 ($past(reset_active) || !boot_overrides_live);
    endsequence

    a_arb_load: assert property (
        load_s |=> settings.arbitration_select
            == $past(reset_config_word[15]))
        else $error("arbitration select not captured");
    a_prefix_load: assert property (
        load_s |=> settings.vector_prefix_init
            == $past(reset_config_word[14]))
        else $error("vector prefix not captured");
    a_drive_load: assert property (
        load_s |=> settings.bus_drive_reduce
            == $past(reset_config_word[13]))
        else $error("drive strength not captured");
    a_width_load: assert property (
        load_s |=> settings.boot_width
            == $past(reset_config_word[11:10]))
        else $error("boot width not captured");
    a_debug_load: assert property (
        load_s |=> settings.debug_pin_config
            == $past(reset_config_word[6:5]))
        else $error("debug pin config not captured");
    a_strobe_load: assert property (
        load_s |=> settings.strobe_type_select
            == $past(reset_config_word[3]))
        else $error("strobe select not captured");
    a_div_load: assert property (
        load_s |=> settings.bus_clock_divide
            == $past(reset_config_word[2:1]))
        else $error("bus clock divide not captured");
    a_lock_flash: assert property (
        load_s |=> settings.interlock_target_select
            == $past(flash_config_word[0]))
        else $error("interlock select not from flash word");
    a_settings_hold: assert property (
        !reset_active |=> $stable(settings))
        else $error("settings moved after reset");
    a_boot_live: assert property (
        bank0_boot_active
            == (boot_overrides_live && !settings.boot_cs_disable)
        && bank0_match_all == bank0_boot_active)
        else $error("bank 0 boot state wrong");
    a_write_ends: assert property (
        sw_write_s |=> live_gone_s)
        else $error("boot overrides survive option write");
    a_rsv_flag: assert property (
        load_s |=> reserved_bits_error
            == |$past(reset_config_word[9:7]))
        else $error("reserved bit flag wrong");
endmodule : rcwd_decode_properties
bind rcwd_decode rcwd_decode_properties u_props (.clk, .rst_n, .reset_active,
    .bank0_option_write, .reset_config_word, .flash_config_word, .settings,
    .bank0_boot_active, .bank0_match_all, .boot_overrides_live,
    .reserved_bits_error);

// *** bench/rcwd_source.sv ***
// Purpose: model of the configuration word source
// Assumes: reserved bits low unless bad_rsv
// Notes: flash word passes straight through
`timescale 1ns/1ps
module rcwd_source (
    input  wire logic [15:0] ext_word,
    input  wire logic [15:0] flash_word,
    input  wire logic        bad_rsv,
    output logic      [15:0] reset_config_word,
    output logic      [15:0] flash_config_word
);
    // reserved bits sit at vector bits 9:7 and are held low unless bad_rsv
    assign reset_config_word = bad_rsv ? ext_word
                                       : ext_word & 16'hFC7F;
    assign flash_config_word = flash_word;
endmodule : rcwd_source

// *** bench/testbench.sv ***
// Purpose: boot the decoder with several words
// Assumes: write ends boot overrides until next reset phase
// Notes: word changes after capture test holding
`timescale 1ns/1ps
module testbench;
    logic clk, rst_n, ra, wr, bad, ba, ma, ol, err;
    logic [15:0] ext, fw, rw, fcw, exp_w;
    rcwd_pkg::rcwd_settings_s st;
    int bad_count = 0, checks_done = 0;
    logic [15:0] wl[4] = '{16'h0000, 16'hAAAA, 16'h5555, 16'hFFFF};
    rcwd_source src (.ext_word(ext), .flash_word(fw), .bad_rsv(bad),
        .reset_config_word(rw), .flash_config_word(fcw));
    rcwd_decode DUT (.clk, .rst_n, .reset_active(ra), .reset_config_word(rw),
        .flash_config_word(fcw), .bank0_option_write(wr), .settings(st),
        .bank0_boot_active(ba), .bank0_match_all(ma),
        .boot_overrides_live(ol), .reserved_bits_error(err));
    task chk(input string n, input logic [15:0] s, e);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task boot(input logic [15:0] w, f, input logic b);
        @(posedge clk); ext <= w; fw <= f; bad <= b; ra <= 1;
        repeat (2) @(posedge clk);
        ra <= 0; ext <= ~w;
        @(posedge clk); @(negedge clk);
    endtask : boot
    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    initial begin clk = 0; forever #10 clk = ~clk; end
    initial begin #20000; bad_count++; end_of_test; end
    initial begin
        rst_n = 0; ra = 1; wr = 0; ext = 0; fw = 0; bad = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1;
        foreach (wl[i]) begin
            boot(wl[i], ~wl[i], 0);
            exp_w = wl[i] & 16'hFC7F;
            chk("arb", 16'(st.arbitration_select), 16'(exp_w[15]));
            chk("prefix", 16'(st.vector_prefix_init), 16'(exp_w[14]));
            chk("drive", 16'(st.bus_drive_reduce), 16'(exp_w[13]));
            chk("boot_dis", 16'(st.boot_cs_disable), 16'(exp_w[12]));
            chk("width", 16'(st.boot_width), 16'(exp_w[11:10]));
            chk("debug", 16'(st.debug_pin_config), 16'(exp_w[6:5]));
            chk("strobe", 16'(st.strobe_type_select), 16'(exp_w[3]));
            chk("divide", 16'(st.bus_clock_divide), 16'(exp_w[2:1]));
            chk("lock", 16'(st.interlock_target_select), 16'(fw[0]));
            chk("boot", 16'(ba), 16'(!wl[i][12]));
            chk("match_all", 16'(ma), 16'(!wl[i][12]));
            @(posedge clk); wr <= 1;
            @(posedge clk); wr <= 0;
            @(negedge clk); chk("boot_off", 16'({ba, ma, ol}), 16'h0);
        end
        @(posedge clk); rst_n <= 0;
        @(negedge clk); chk("rst_settings", 16'(st), 16'h0);
        chk("rst_boot", 16'({ba, ma, ol, err}), 16'hE);
        @(posedge clk); rst_n <= 1;
        boot(16'h0380, 16'h0, 1); chk("rsv", 16'(err), 16'h1);
        end_of_test;
    end
endmodule : testbench
